// ---- bench/dram_ctrl_model.sv ----
// Behavioural model of the dynamic RAM controller side: refresh request handshake
`timescale 1ns/1ns
`default_nettype none
module dram_ctrl_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic kick,
  input wire logic mode_select,
  output logic refresh_request_in_n
);
  always @(posedge clk) begin
    if (!nrst) begin
      refresh_request_in_n <= 1'h1;
    end else if (kick) begin
      refresh_request_in_n <= 1'h0;
    end else if (mode_select === 1'h1) begin
      // Request is withdrawn once the forced refresh has been seen
      refresh_request_in_n <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/test_dram_access_refresh_sequencer.sv ----
// Self-checking testbench of the dram access and refresh sequencer
`timescale 1ns/1ns
`default_nettype none
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module test_dram_access_refresh_sequencer;
  logic clk, nrst, chip_select_n, address_strobe_n, data_direction_in, cycle_phase_strobe;
  logic write_wait_req_n, read_wait_req_n, refresh_request_in_n, refresh_window_clock, output_enable_n;
  logic row_strobe_request_n, access_done_n, mode_select, bus_cycle_active_n;
  logic cpu_wait_out_n, cpu_wait_oe_n, outputs_oe_n, kick;
  int failures = 0;
  int check_count = 0;
  logic [31:0] exp_q[$];
  logic in_cyc, rs_s, dn_s, oe_bad, rs_bad, d, r, w;
  logic [1:0] wc;
  logic [5:0] dl;
  logic [7:0] mc;
  logic [3:0] cs_hist = 4'h0;
  logic [6:0] idle_outs;
  int unsigned rnd;

  dram_access_refresh_sequencer dram_access_refresh_sequencer_inst (.clk(clk), .nrst(nrst),
    .chip_select_n(chip_select_n), .address_strobe_n(address_strobe_n), .data_direction_in(data_direction_in),
    .cycle_phase_strobe(cycle_phase_strobe), .write_wait_req_n(write_wait_req_n),
    .read_wait_req_n(read_wait_req_n), .refresh_request_in_n(refresh_request_in_n),
    .refresh_window_clock(refresh_window_clock), .output_enable_n(output_enable_n),
    .row_strobe_request_n(row_strobe_request_n), .access_done_n(access_done_n), .mode_select(mode_select),
    .bus_cycle_active_n(bus_cycle_active_n), .cpu_wait_out_n(cpu_wait_out_n), .cpu_wait_oe_n(cpu_wait_oe_n),
    .outputs_oe_n(outputs_oe_n));

  dram_ctrl_model dram_ctrl_model_inst (.clk(clk), .nrst(nrst), .kick(kick), .mode_select(mode_select),
    .refresh_request_in_n(refresh_request_in_n));

  assign idle_outs = {row_strobe_request_n, access_done_n, mode_select, bus_cycle_active_n, cpu_wait_out_n,
                      cpu_wait_oe_n, outputs_oe_n};

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    if (exp_q.size() != 0) failures++;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Bus record: rs seen, done seen, done at end, wait driven while deselected, wait count, strobe delay
  function automatic logic [31:0] bexp(input logic rs, input logic dn, input logic [1:0] n, input logic [5:0] t,
                                       input logic [15:0] msk);
    return {4'h0, rs, dn, 1'h1, 1'h0, n, t, msk};
  endfunction

  task automatic push_refresh();
    exp_q.push_back({1'h1, 7'h0, 8'(dram_seq_pkg::FORCE_REFRESH_CYCLES), 16'hffff});
  endtask

  task automatic take(input logic [15:0] rec);
    logic [31:0] e;
    if (exp_q.size() == 0) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, rec, 16'h0);
    end else begin
      e = exp_q.pop_front();
      `check_eq(rec & e[15:0], e[31:16] & e[15:0])
    end
  endtask

  task automatic bus_cycle(input logic cs, input logic dir, input logic rw, input logic ww, input logic win,
                           input int hold);
    @(posedge clk);
    chip_select_n <= cs;
    data_direction_in <= dir;
    read_wait_req_n <= rw;
    write_wait_req_n <= ww;
    refresh_window_clock <= win;
    address_strobe_n <= 1'h0;
    repeat (3) @(posedge clk);
    address_strobe_n <= 1'h1;
    @(posedge clk);
    cycle_phase_strobe <= 1'h0;
    repeat (hold) @(posedge clk);
    cycle_phase_strobe <= 1'h1;
    repeat (8) @(posedge clk);
    chip_select_n <= 1'h1;
  endtask

  // Output watcher: builds a record per bus cycle and per forced refresh
  always @(negedge clk) begin
    cs_hist = {cs_hist[2:0], chip_select_n};
    if (!nrst) begin
      {in_cyc, rs_s, dn_s, oe_bad, rs_bad, wc, dl, mc} = '0;
    end else begin
      // Two sync stages plus the output flop: float is due on the fourth negedge
      if (cs_hist == 4'hf && cpu_wait_oe_n !== 1'h1) oe_bad = 1'h1;
      if (bus_cycle_active_n === 1'h0) begin
        in_cyc = 1'h1;
        if (row_strobe_request_n === 1'h1 && !rs_s && !cycle_phase_strobe) dl = dl + 6'h1;
        if (row_strobe_request_n === 1'h0) rs_s = 1'h1;
        if (access_done_n === 1'h0) dn_s = 1'h1;
        if (cpu_wait_out_n === 1'h0 && wc != 2'h2) wc = wc + 2'h1;
        if (cpu_wait_out_n === 1'h0 && cpu_wait_oe_n !== 1'h0) oe_bad = 1'h1;
      end else if (in_cyc) begin
        take({4'h0, rs_s, dn_s, access_done_n, oe_bad, wc, dl});
        {in_cyc, rs_s, dn_s, oe_bad, wc, dl} = '0;
      end
      if (mode_select === 1'h1) begin
        mc = mc + 8'h1;
        if (row_strobe_request_n !== 1'h0) rs_bad = 1'h1;
      end else if (mc != 8'h0) begin
        take({1'h1, 6'h0, rs_bad, mc});
        {mc, rs_bad} = '0;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end

  initial begin
    {nrst, data_direction_in, output_enable_n, refresh_window_clock, kick} = '0;
    {chip_select_n, address_strobe_n, cycle_phase_strobe, write_wait_req_n, read_wait_req_n} = 5'h1f;
    rnd = $urandom(32'he488);
    repeat (15) @(posedge clk);
    @(negedge clk);
    `check_eq(idle_outs, 7'h6f)
    @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    output_enable_n <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `check_eq(outputs_oe_n, 1'h1)
    @(posedge clk);
    output_enable_n <= 1'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `check_eq(outputs_oe_n, 1'h0)
    for (int i = 0; i < 12; i++) begin
      {d, r, w} = 3'($urandom());
      if (d) exp_q.push_back(bexp(1'h1, 1'h1, {1'h0, ~w}, 6'h4, 16'hffff));
      else exp_q.push_back(bexp(1'h1, 1'h1, {1'h0, ~r}, 6'h3, r ? 16'hffff : 16'hffc0));
      bus_cycle(1'h0, d, r, w, 1'h0, 8);
    end
    exp_q.push_back(bexp(1'h0, 1'h0, 2'h0, 6'h0, 16'hffc0));
    bus_cycle(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8);
    for (int i = 0; i < 3; i++) begin
      {d, r, w} = 3'($urandom());
      exp_q.push_back(bexp(1'h1, 1'h1, 2'h0, 6'h0, 16'hffc0));
      bus_cycle(1'h1, d, r, w, 1'h1, 8);
    end
    push_refresh();
    @(posedge clk);
    refresh_window_clock <= 1'h0;
    kick <= 1'h1;
    @(posedge clk);
    kick <= 1'h0;
    repeat (24) @(posedge clk);
    push_refresh();
    exp_q.push_back(bexp(1'h1, 1'h1, 2'h2, 6'h0, 16'hffc0));
    kick <= 1'h1;
    @(posedge clk);
    kick <= 1'h0;
    for (int i = 0; i < 20 && mode_select !== 1'h1; i++) @(posedge clk);
    bus_cycle(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 20);
    repeat (8) @(posedge clk);
    push_refresh();
    exp_q.push_back(bexp(1'h0, 1'h0, 2'h0, 6'h0, 16'hf3c0));
    fork
      bus_cycle(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 40);
      begin
        repeat (8) @(posedge clk);
        kick <= 1'h1;
        @(posedge clk);
        kick <= 1'h0;
      end
    join
    repeat (20) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- rtl/dram_access_refresh_sequencer.sv ----
// Access, wait and refresh sequencer between a processor bus and a dynamic RAM controller
`timescale 1ns/1ns
`default_nettype none
module dram_access_refresh_sequencer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select_n,
  input wire logic address_strobe_n,
  input wire logic data_direction_in,
  input wire logic cycle_phase_strobe,
  input wire logic write_wait_req_n,
  input wire logic read_wait_req_n,
  input wire logic refresh_request_in_n,
  input wire logic refresh_window_clock,
  input wire logic output_enable_n,
  output logic row_strobe_request_n,
  output logic access_done_n,
  output logic mode_select,
  output logic bus_cycle_active_n,
  output logic cpu_wait_out_n,
  output logic cpu_wait_oe_n,
  output logic outputs_oe_n
);

  typedef struct packed {
    dram_seq_pkg::seq_state_e st;
    logic ras;
    logic ras_n;
    logic done_n;
    logic mode;
    logic active_n;
    logic seen_t2;
    logic as_prev_n;
    logic is_read;
    logic pend;
    logic wait_n;
    logic wait_oe_n;
    logic out_oe_n;
    logic [2:0] dly;
    logic [3:0] cnt;
  } seq_s;

  seq_s r;
  seq_s next_r;

  logic [dram_seq_pkg::SYNC_INPUTS-1:0] pins;
  logic [dram_seq_pkg::SYNC_INPUTS-1:0] synced;

  logic s_cs_n;
  logic s_as_n;
  logic s_data_direction_in;
  logic s_tso;
  logic s_wwr_n;
  logic s_wrd_n;
  logic s_refresh_request_n;
  logic s_refresh_window_clock;
  logic s_oe_n;
  logic as_fall;

  assign pins = {output_enable_n, refresh_window_clock, refresh_request_in_n, read_wait_req_n,
                 write_wait_req_n, cycle_phase_strobe, data_direction_in, address_strobe_n, chip_select_n};

  // Idle levels: strobes and requests high, window clock low
  pin_sync #(
    .W(dram_seq_pkg::SYNC_INPUTS),
    .INIT(dram_seq_pkg::SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pins),
    .q(synced)
  );

  assign s_cs_n = synced[0];
  assign s_as_n = synced[1];
  assign s_data_direction_in = synced[2];
  assign s_tso = synced[3];
  assign s_wwr_n = synced[4];
  assign s_wrd_n = synced[5];
  assign s_refresh_request_n = synced[6];
  assign s_refresh_window_clock = synced[7];
  assign s_oe_n = synced[8];

  assign as_fall = r.as_prev_n && !s_as_n;

  always_comb begin
    next_r = r;
    next_r.as_prev_n = s_as_n;
    next_r.dly = {r.dly[1:0], 1'b0};
    next_r.out_oe_n = s_oe_n;
    next_r.wait_oe_n = s_cs_n;
    if (r.cnt != dram_seq_pkg::COUNT_RESET) begin
      next_r.cnt = r.cnt - 4'h1;
    end

    // Bus cycle tracking for any access in the system
    if (as_fall) begin
      next_r.active_n = 1'b0;
      next_r.seen_t2 = 1'b0;
    end else if (!r.active_n && !s_tso) begin
      next_r.seen_t2 = 1'b1;
    end else if (!r.active_n && r.seen_t2 && s_tso) begin
      next_r.active_n = 1'b1;
      next_r.seen_t2 = 1'b0;
    end

    unique case (r.st)
      dram_seq_pkg::ST_IDLE: begin
        next_r.ras = 1'b0;
        next_r.wait_n = 1'b1;
        if (!s_refresh_request_n) begin
          // No memory access runs here, even inside a long foreign cycle
          next_r.st = dram_seq_pkg::ST_FORCE;
          next_r.mode = dram_seq_pkg::MODE_FORCED;
          next_r.ras = 1'b1;
          next_r.cnt = dram_seq_pkg::FORCE_LOAD;
          next_r.pend = as_fall && !s_cs_n;
          if (as_fall && !s_cs_n) begin
            next_r.wait_n = 1'b0;
          end
        end else if (as_fall && !s_cs_n) begin
          next_r.st = dram_seq_pkg::ST_MEM_T1;
        end else if (!r.active_n && s_cs_n && !s_tso && s_refresh_window_clock && r.done_n) begin
          // Foreign access: the controller refreshes under this row strobe
          next_r.st = dram_seq_pkg::ST_HIDDEN;
          next_r.ras = 1'b1;
          next_r.done_n = 1'b0;
        end
      end
      dram_seq_pkg::ST_MEM_T1: begin
        next_r.is_read = !s_data_direction_in;
        if (!s_tso) begin
          if (!s_data_direction_in) begin
            next_r.ras = 1'b1;
            if (!s_wrd_n) begin
              next_r.wait_n = 1'b0;
              next_r.dly = 3'h1;
              next_r.st = dram_seq_pkg::ST_MEM_READ_WAIT;
            end else begin
              next_r.done_n = 1'b0;
              next_r.st = dram_seq_pkg::ST_MEM_END;
            end
          end else begin
            // Writes hold the row strobe for one delay stage
            next_r.dly = 3'h1;
            next_r.wait_n = s_wwr_n;
            next_r.st = dram_seq_pkg::ST_MEM_WRITE;
          end
        end
      end
      dram_seq_pkg::ST_MEM_WRITE: begin
        if (r.dly[0]) begin
          next_r.ras = 1'b1;
          next_r.wait_n = 1'b1;
          next_r.done_n = 1'b0;
          next_r.st = dram_seq_pkg::ST_MEM_END;
        end
      end
      dram_seq_pkg::ST_MEM_READ_WAIT: begin
        if (r.dly[0]) begin
          next_r.wait_n = 1'b1;
          next_r.done_n = 1'b0;
          next_r.st = dram_seq_pkg::ST_MEM_END;
        end
      end
      dram_seq_pkg::ST_MEM_END, dram_seq_pkg::ST_HIDDEN: begin
        next_r.wait_n = 1'b1;
        if (s_tso) begin
          next_r.ras = 1'b0;
          next_r.done_n = 1'b1;
          next_r.st = dram_seq_pkg::ST_IDLE;
        end
      end
      dram_seq_pkg::ST_FORCE: begin
        if (as_fall && !s_cs_n) begin
          next_r.pend = 1'b1;
          next_r.wait_n = 1'b0;
        end
        if (r.cnt == dram_seq_pkg::COUNT_RESET) begin
          next_r.ras = 1'b0;
          next_r.mode = dram_seq_pkg::MODE_ACCESS;
          next_r.cnt = dram_seq_pkg::PRECHARGE_LOAD;
          next_r.st = dram_seq_pkg::ST_PRECHARGE;
        end
      end
      dram_seq_pkg::ST_PRECHARGE: begin
        if (as_fall && !s_cs_n) begin
          next_r.pend = 1'b1;
          next_r.wait_n = 1'b0;
        end
        if (r.cnt == dram_seq_pkg::COUNT_RESET) begin
          if (r.pend || (as_fall && !s_cs_n)) begin
            // Pending access runs at once, its T2 has already passed
            next_r.ras = 1'b1;
            next_r.wait_n = 1'b1;
            next_r.done_n = 1'b0;
            next_r.pend = 1'b0;
            next_r.is_read = !s_data_direction_in;
            next_r.st = dram_seq_pkg::ST_MEM_END;
          end else begin
            next_r.st = dram_seq_pkg::ST_IDLE;
          end
        end
      end
    endcase

    if (!nrst) begin
      next_r.st = dram_seq_pkg::ST_IDLE;
      next_r.ras = 1'b0;
      next_r.done_n = 1'b1;
      next_r.mode = dram_seq_pkg::MODE_ACCESS;
      next_r.active_n = 1'b1;
      next_r.seen_t2 = 1'b0;
      next_r.as_prev_n = 1'b1;
      next_r.is_read = 1'b0;
      next_r.pend = 1'b0;
      next_r.wait_n = 1'b1;
      next_r.wait_oe_n = 1'b1;
      next_r.out_oe_n = 1'b1;
      next_r.dly = dram_seq_pkg::DELAY_RESET;
      next_r.cnt = dram_seq_pkg::COUNT_RESET;
    end
    // Inverted copy in its own flop so the pin comes straight from a register
    next_r.ras_n = !next_r.ras;
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign row_strobe_request_n = r.ras_n;
  assign access_done_n = r.done_n;
  assign mode_select = r.mode;
  assign bus_cycle_active_n = r.active_n;
  assign cpu_wait_out_n = r.wait_n;
  assign cpu_wait_oe_n = r.wait_oe_n;
  assign outputs_oe_n = r.out_oe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_start_needs_select;
    (r.st == dram_seq_pkg::ST_IDLE) ##1 (r.st == dram_seq_pkg::ST_MEM_T1) |-> $past(!s_cs_n) && $past(as_fall);
  endproperty
  a_start_needs_select: assert property (p_start_needs_select) else $error("access started without select");

  property p_read_ras_at_t2;
    (r.st == dram_seq_pkg::ST_MEM_T1) && !s_tso && !s_data_direction_in |=> r.ras;
  endproperty
  a_read_ras_at_t2: assert property (p_read_ras_at_t2) else $error("read row strobe late");

  property p_write_ras_later;
    (r.st == dram_seq_pkg::ST_MEM_T1) && !s_tso && s_data_direction_in |=> !r.ras ##1 r.ras;
  endproperty
  a_write_ras_later: assert property (p_write_ras_later) else $error("write row strobe timing wrong");

  property p_write_wait_one;
    (r.st == dram_seq_pkg::ST_MEM_T1) && !s_tso && s_data_direction_in && !s_wwr_n |=> !r.wait_n ##1 r.wait_n;
  endproperty
  a_write_wait_one: assert property (p_write_wait_one) else $error("write wait state wrong");

  property p_read_wait_one;
    (r.st == dram_seq_pkg::ST_MEM_T1) && !s_tso && !s_data_direction_in && !s_wrd_n |=> !r.wait_n ##1 (r.wait_n && !r.done_n);
  endproperty
  a_read_wait_one: assert property (p_read_wait_one) else $error("read wait state not exactly one");

  property p_done_clear;
    !r.done_n && s_tso && (r.st == dram_seq_pkg::ST_MEM_END || r.st == dram_seq_pkg::ST_HIDDEN) |=> r.done_n && !r.ras;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("access done not cleared at cycle end");

  property p_wait_float;
    s_cs_n |=> r.wait_oe_n;
  endproperty
  a_wait_float: assert property (p_wait_float) else $error("wait driven while deselected");

  property p_active_on_strobe;
    as_fall |=> !r.active_n;
  endproperty
  a_active_on_strobe: assert property (p_active_on_strobe) else $error("bus cycle active missed");

  property p_mode_only_refresh;
    r.mode |-> (r.st == dram_seq_pkg::ST_FORCE);
  endproperty
  a_mode_only_refresh: assert property (p_mode_only_refresh) else $error("mode select outside forced refresh");

  property p_hidden_no_wait;
    (r.st == dram_seq_pkg::ST_HIDDEN) |-> r.wait_n && r.ras;
  endproperty
  a_hidden_no_wait: assert property (p_hidden_no_wait) else $error("wait during hidden refresh");

  property p_force_from_request;
    (r.st == dram_seq_pkg::ST_IDLE) && !s_refresh_request_n |=> r.mode && r.ras;
  endproperty
  a_force_from_request: assert property (p_force_from_request) else $error("forced refresh not started");

  property p_pending_waits;
    (r.st == dram_seq_pkg::ST_FORCE) && as_fall && !s_cs_n |=> !r.wait_n;
  endproperty
  a_pending_waits: assert property (p_pending_waits) else $error("no wait for access during refresh");

  property p_oe_follows;
    s_oe_n |=> r.out_oe_n;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("outputs enabled without enable");

  property p_done_with_ras;
    (r.st == dram_seq_pkg::ST_MEM_END) |-> !r.done_n && r.ras;
  endproperty
  a_done_with_ras: assert property (p_done_with_ras) else $error("access done without row strobe");

  property p_force_in_foreign;
    (r.st == dram_seq_pkg::ST_IDLE) && !s_refresh_request_n && !r.active_n && s_cs_n |=> (r.st == dram_seq_pkg::ST_FORCE);
  endproperty
  a_force_in_foreign: assert property (p_force_in_foreign) else $error("no forced refresh in foreign cycle");

  property p_write_delay;
    (r.st == dram_seq_pkg::ST_MEM_WRITE) |-> r.dly[0] && !r.ras;
  endproperty
  a_write_delay: assert property (p_write_delay) else $error("write delay stage wrong");

  property p_precharge_quiet;
    (r.st == dram_seq_pkg::ST_PRECHARGE) |-> !r.ras && !r.mode;
  endproperty
  a_precharge_quiet: assert property (p_precharge_quiet) else $error("row strobe during precharge");

  c_read_cycle: cover property ((r.st == dram_seq_pkg::ST_MEM_T1) ##1 (r.st == dram_seq_pkg::ST_MEM_END));
  c_hidden: cover property (r.st == dram_seq_pkg::ST_HIDDEN);
  c_force_pending: cover property ((r.st == dram_seq_pkg::ST_PRECHARGE) && r.pend);
  c_write_cycle: cover property ((r.st == dram_seq_pkg::ST_MEM_END) && !r.is_read);

endmodule
`default_nettype wire

// ---- rtl/dram_seq_pkg.sv ----
// Shared constants and types of the dram access and refresh sequencer
package dram_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Row strobe held by the controller for one forced refresh
  localparam int unsigned FORCE_REFRESH_NS = 60;
  // Row precharge to be met after a forced refresh
  localparam int unsigned PRECHARGE_NS = 30;

  // Least times round up to whole clock cycles
  localparam int unsigned FORCE_REFRESH_CYCLES = (FORCE_REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_CYCLES = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] FORCE_LOAD = 4'(FORCE_REFRESH_CYCLES - 1);
  localparam logic [3:0] PRECHARGE_LOAD = 4'(PRECHARGE_CYCLES - 1);

  // Number of pin inputs carried through the synchroniser
  localparam int unsigned SYNC_INPUTS = 9;

  // Values after reset
  localparam logic [2:0] DELAY_RESET = 3'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  // Synchroniser idle levels: strobes and requests high, window clock low
  localparam logic [8:0] SYNC_RESET = 9'h17f;

  // Controller mode select: low keeps the access mode, high the forced refresh mode
  localparam logic MODE_ACCESS = 1'h0;
  localparam logic MODE_FORCED = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_MEM_T1 = 4'h1,
    ST_MEM_WRITE = 4'h2,
    ST_MEM_READ_WAIT = 4'h3,
    ST_MEM_END = 4'h4,
    ST_HIDDEN = 4'h5,
    ST_FORCE = 4'h6,
    ST_PRECHARGE = 4'h7
  } seq_state_e;

endpackage

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_s;

  sync_s r;
  sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.first = d;
    // Only the second stage reads the first
    next_r.second = r.first;
    if (!nrst) begin
      next_r.first = INIT;
      next_r.second = INIT;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign q = r.second;

endmodule
`default_nettype wire
